//--- pkg/wim_map.vh
// Register offsets, field positions, reset values and timing counts of the wake input monitor.
`ifndef WIM_MAP_VH
`define WIM_MAP_VH
`define WIM_ADDR_W            4
`define WIM_OFF_WAKE_CTRL1    4'h0
`define WIM_OFF_HW_CTRL0      4'h1
`define WIM_OFF_PULL_CTRL     4'h2
`define WIM_OFF_STATUS0       4'h3
`define WIM_OFF_LEVEL_STAT    4'h4
`define WIM_OFF_MODE          4'h5
`define WIM_BIT_WAKE_EN       0
`define WIM_BIT_REG_BY_PIN    0
`define WIM_BIT_PULL_LO       0
`define WIM_BIT_PULL_HI       1
`define WIM_BIT_EVENT_FLAG    0
`define WIM_BIT_LEVEL         0
`define WIM_RST_WAKE_CTRL1    1'b0
`define WIM_RST_REG_BY_PIN    1'b0
`define WIM_RST_PULL          2'b00
`define WIM_PULL_NONE         2'b00
`define WIM_PULL_DOWN         2'b01
`define WIM_PULL_UP           2'b10
`define WIM_PULL_AUTO         2'b11
`define WIM_MODE_NORMAL       2'b00
`define WIM_MODE_STOP         2'b01
`define WIM_MODE_SLEEP        2'b10
`define WIM_MODE_FAILSAFE     2'b11
`define WIM_CLK_MHZ           250
`define WIM_FILTER_MIN_US     12
`define WIM_FILTER_TYP_US     16
`define WIM_FILTER_MAX_US     20
`define WIM_INT_PULSE_MIN_US  80
`define WIM_INT_PULSE_MAX_US  120
`define WIM_INT_GAP_MIN_US    80
`define WIM_FILTER_CYC        (`WIM_FILTER_TYP_US * `WIM_CLK_MHZ)
`define WIM_INT_PULSE_CYC     (`WIM_INT_PULSE_MIN_US * `WIM_CLK_MHZ)
`define WIM_INT_GAP_CYC       (`WIM_INT_GAP_MIN_US * `WIM_CLK_MHZ)
`endif

//--- verilog/wim_filter.v
// Synchroniser and stability filter for the wake comparator output.
`timescale 1ns/1ps
module wim_filter #(
    parameter CNT_W  = 16,
    parameter FILT_N = 4000
) (
    input  wire clk_sys,
    input  wire nrst,
    input  wire pin_in,
    output reg  raw_level,
    output reg  filt_level
);
    reg             sync_a;
    reg [CNT_W-1:0] stable_cnt;

    // The first stage is read only by raw_level, which then feeds the bypass path and the filter.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            sync_a     <= 1'b0;
            raw_level  <= 1'b0;
            filt_level <= 1'b0;
            stable_cnt <= {CNT_W{1'b0}};
        end else begin
            sync_a    <= pin_in;
            raw_level <= sync_a;
            if (raw_level == filt_level) begin
                stable_cnt <= {CNT_W{1'b0}};
            end else if (stable_cnt == FILT_N[CNT_W-1:0] - 1'b1) begin
                filt_level <= raw_level;
                stable_cnt <= {CNT_W{1'b0}};
            end else begin
                stable_cnt <= stable_cnt + 1'b1;
            end
        end
    end
endmodule

//--- verilog/wim_top.v
// Wake input monitor: filtered edge events, interrupt pulse, wake requests, regulator steering and pull select.
`timescale 1ns/1ps
`include "wim_map.vh"
module wim_top #(
    parameter FILTER_CYC = `WIM_FILTER_CYC,
    parameter PULSE_CYC  = `WIM_INT_PULSE_CYC,
    parameter GAP_CYC    = `WIM_INT_GAP_CYC,
    parameter CNT_W      = 16
) (
    input  wire                   clk_sys,
    input  wire                   nrst,
    input  wire                   wake_pin,
    input  wire [1:0]             chip_mode,
    input  wire [`WIM_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    output reg                    interrupt_out_n,
    output reg                    wake_req,
    output reg                    restart_req,
    output reg                    buck_pwm_sel,
    output reg                    buck_pin_ctrl,
    output reg                    pull_up_en,
    output reg                    pull_down_en
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_PULSE = 3'b010;
    localparam ST_GAP   = 3'b100;

    wire             raw_level;
    wire             filt_level;
    reg              wake_pin_enable;
    reg              regulator_mode_by_pin;
    reg  [1:0]       wake_pull_control;
    reg              wake_pin_event_flag;
    reg              last_level;
    reg  [1:0]       mode_q;
    reg              int_pending;
    reg  [2:0]       int_state;
    reg  [CNT_W-1:0] int_cnt;
    reg              next_pull_up;
    reg              next_pull_down;
    wire             level_change;
    wire             run_mode;
    wire             sleep_mode;
    wire             fs_mode;
    wire             wake_event;
    wire             int_event;
    wire             flag_clear;
    wire             wr_wake_ctrl;
    wire             wr_hw_ctrl;
    wire             wr_pull_ctrl;
    reg  [7:0]       next_rdata;

    // Chip mode comes from the device's own mode controller on this clock.
    function is_mode;
        input [1:0] m;
        input [1:0] want;
        begin
            is_mode = (m == want);
        end
    endfunction

    // Register select; shared by the write strobes and the clear-on-read decode.
    function reg_hit;
        input [`WIM_ADDR_W-1:0] a;
        input [`WIM_ADDR_W-1:0] want;
        begin
            reg_hit = (a == want);
        end
    endfunction

    // The comparator output is asynchronous, so the filter also carries the two-stage synchroniser.
    wim_filter #(
        .CNT_W  (CNT_W),
        .FILT_N (FILTER_CYC)
    ) u_filter (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .pin_in     (wake_pin),
        .raw_level  (raw_level),
        .filt_level (filt_level)
    );

    assign run_mode   = is_mode(chip_mode, `WIM_MODE_NORMAL) | is_mode(chip_mode, `WIM_MODE_STOP);
    assign sleep_mode = is_mode(chip_mode, `WIM_MODE_SLEEP);
    assign fs_mode    = is_mode(chip_mode, `WIM_MODE_FAILSAFE);
    assign level_change = (filt_level != last_level);
    // Fail-Safe ignores the enable; other modes need it.
    assign wake_event = level_change & (fs_mode | wake_pin_enable);
    assign int_event  = wake_event & run_mode;
    assign flag_clear   = reg_rd & reg_hit(reg_addr, `WIM_OFF_STATUS0);
    // Status, level and mode offsets are read-only, so writes to them fall away.
    assign wr_wake_ctrl = reg_wr & reg_hit(reg_addr, `WIM_OFF_WAKE_CTRL1);
    assign wr_hw_ctrl   = reg_wr & reg_hit(reg_addr, `WIM_OFF_HW_CTRL0);
    assign wr_pull_ctrl = reg_wr & reg_hit(reg_addr, `WIM_OFF_PULL_CTRL);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            last_level <= 1'b0;
            mode_q     <= `WIM_MODE_NORMAL;
        end else begin
            mode_q <= chip_mode;
            if (level_change) begin
                last_level <= filt_level;
            end
        end
    end

    // Control registers; each one loads only on its own write strobe.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            wake_pin_enable <= `WIM_RST_WAKE_CTRL1;
        end else if (wr_wake_ctrl) begin
            wake_pin_enable <= reg_wdata[`WIM_BIT_WAKE_EN];
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            regulator_mode_by_pin <= `WIM_RST_REG_BY_PIN;
        end else if (wr_hw_ctrl) begin
            regulator_mode_by_pin <= reg_wdata[`WIM_BIT_REG_BY_PIN];
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            wake_pull_control <= `WIM_RST_PULL;
        end else if (wr_pull_ctrl) begin
            wake_pull_control <= reg_wdata[`WIM_BIT_PULL_HI:`WIM_BIT_PULL_LO];
        end
    end

    // The flag clears on a read of the status offset; a new event in the same cycle wins so no edge is lost.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            wake_pin_event_flag <= 1'b0;
        end else if (wake_event) begin
            wake_pin_event_flag <= 1'b1;
        end else if (flag_clear) begin
            wake_pin_event_flag <= 1'b0;
        end
    end

    // Read data is zero except in the one cycle after a read strobe.
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `WIM_OFF_WAKE_CTRL1: begin
                    next_rdata = {7'h00, wake_pin_enable};
                end
                `WIM_OFF_HW_CTRL0: begin
                    next_rdata = {7'h00, regulator_mode_by_pin};
                end
                `WIM_OFF_PULL_CTRL: begin
                    next_rdata = {6'h00, wake_pull_control};
                end
                `WIM_OFF_STATUS0: begin
                    next_rdata = {7'h00, wake_pin_event_flag};
                end
                // Live level only in Normal/Stop, never latched.
                `WIM_OFF_LEVEL_STAT: begin
                    next_rdata = {7'h00, filt_level & run_mode};
                end
                `WIM_OFF_MODE: begin
                    next_rdata = {6'h00, mode_q};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Interrupt pulse engine; events during a pulse or gap are held and issued after the gap.
    // Pulse and gap share one counter, so CNT_W must hold the larger of the two counts.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            int_state       <= ST_IDLE;
            int_cnt         <= {CNT_W{1'b0}};
            int_pending     <= 1'b0;
            interrupt_out_n <= 1'b1;
        end else begin
            if (int_event) begin
                int_pending <= 1'b1;
            end
            case (int_state)
                ST_IDLE: begin
                    if (int_pending | int_event) begin
                        int_state       <= ST_PULSE;
                        int_pending     <= 1'b0;
                        int_cnt         <= {CNT_W{1'b0}};
                        interrupt_out_n <= 1'b0;
                    end
                end
                ST_PULSE: begin
                    if (int_cnt == PULSE_CYC[CNT_W-1:0] - 1'b1) begin
                        int_state       <= ST_GAP;
                        int_cnt         <= {CNT_W{1'b0}};
                        interrupt_out_n <= 1'b1;
                    end else begin
                        int_cnt <= int_cnt + 1'b1;
                    end
                end
                ST_GAP: begin
                    if (int_cnt == GAP_CYC[CNT_W-1:0] - 1'b1) begin
                        int_state <= ST_IDLE;
                        int_cnt   <= {CNT_W{1'b0}};
                    end else begin
                        int_cnt <= int_cnt + 1'b1;
                    end
                end
                default: begin
                    int_state       <= ST_IDLE;
                    interrupt_out_n <= 1'b1;
                end
            endcase
        end
    end

    // Wake and restart requests are one-cycle pulses to the mode controller.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            wake_req    <= 1'b0;
            restart_req <= 1'b0;
        end else begin
            wake_req    <= wake_event & sleep_mode;
            restart_req <= level_change & fs_mode;
        end
    end

    // Regulator steering uses the unfiltered synchronised level since the source is assumed clean.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            buck_pin_ctrl <= 1'b0;
            buck_pwm_sel  <= 1'b0;
        end else begin
            buck_pin_ctrl <= regulator_mode_by_pin & is_mode(chip_mode, `WIM_MODE_STOP);
            buck_pwm_sel  <= raw_level;
        end
    end

    always @* begin
        next_pull_up   = 1'b0;
        next_pull_down = 1'b0;
        case (wake_pull_control)
            `WIM_PULL_NONE: begin
            end
            `WIM_PULL_DOWN: begin
                next_pull_down = 1'b1;
            end
            `WIM_PULL_UP: begin
                next_pull_up = 1'b1;
            end
            `WIM_PULL_AUTO: begin
                next_pull_up   = filt_level;
                next_pull_down = ~filt_level;
            end
            default: begin
            end
        endcase
    end

    // Pull enables are registered so the current sources never see a decode glitch.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pull_up_en   <= 1'b0;
            pull_down_en <= 1'b0;
        end else begin
            pull_up_en   <= next_pull_up;
            pull_down_en <= next_pull_down;
        end
    end
endmodule

//--- verif/wim_top_sva.sv
// Concurrent checks on the ports of the wake input monitor.
`timescale 1ns/1ps
`include "wim_map.vh"
module wim_chk #(
    parameter int FILTER_CYC = 8,
    parameter int PULSE_CYC  = 16,
    parameter int GAP_CYC    = 16
) (
    input wire       clk_sys,
    input wire       nrst,
    input wire       wake_pin,
    input wire [1:0] chip_mode,
    input wire       interrupt_out_n,
    input wire       wake_req,
    input wire       restart_req,
    input wire       buck_pin_ctrl,
    input wire       pull_up_en,
    input wire       pull_down_en
);
    logic [7:0] hi_cnt;
    logic [7:0] st_cnt;
    logic       pin_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // The gap counter starts saturated so the first pulse after reset is not held to a gap.
    always @(posedge clk_sys) begin
        pin_q <= wake_pin;
        st_cnt <= (wake_pin != pin_q) ? 8'h00 : st_cnt + {7'h00, st_cnt != 8'hff};
        if (!nrst) hi_cnt <= 8'hff;
        else if (!interrupt_out_n) hi_cnt <= 8'h00;
        else hi_cnt <= hi_cnt + {7'h00, hi_cnt != 8'hff};
    end
    sequence s_release;
        ##PULSE_CYC $rose(interrupt_out_n);
    endsequence
    property p_pulse; $fell(interrupt_out_n) |-> s_release; endproperty
    property p_gap; $fell(interrupt_out_n) |-> hi_cnt >= GAP_CYC; endproperty
    property p_filter; (wake_req || restart_req) |-> st_cnt >= FILTER_CYC; endproperty
    property p_int_mode; $fell(interrupt_out_n) |-> !$past(chip_mode[1]); endproperty
    property p_wake; wake_req |-> $past(chip_mode) == `WIM_MODE_SLEEP; endproperty
    property p_restart; restart_req |-> $past(chip_mode) == `WIM_MODE_FAILSAFE; endproperty
    property p_one; (wake_req || restart_req) |=> !(wake_req || restart_req); endproperty
    property p_buck; buck_pin_ctrl |-> $past(chip_mode) == `WIM_MODE_STOP; endproperty
    property p_pull; !(pull_up_en && pull_down_en); endproperty
    a_pulse: assert property (p_pulse) else $error("interrupt pulse length wrong");
    a_gap: assert property (p_gap) else $error("interrupt gap too short");
    a_filter: assert property (p_filter) else $error("event before filter time");
    a_int_mode: assert property (p_int_mode) else $error("interrupt outside normal or stop");
    a_wake: assert property (p_wake) else $error("wake request outside sleep");
    a_restart: assert property (p_restart) else $error("restart outside fail-safe");
    a_one: assert property (p_one) else $error("request longer than one cycle");
    a_buck: assert property (p_buck) else $error("regulator steering outside stop");
    a_pull: assert property (p_pull) else $error("both pull currents on");
endmodule
bind wim_top wim_chk #(.FILTER_CYC(FILTER_CYC), .PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) wim_chk_i (
    .clk_sys(clk_sys), .nrst(nrst), .wake_pin(wake_pin), .chip_mode(chip_mode),
    .interrupt_out_n(interrupt_out_n), .wake_req(wake_req), .restart_req(restart_req),
    .buck_pin_ctrl(buck_pin_ctrl), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

//--- verif/wim_switch.sv
// Model of the external switch driving the wake pin, with contact bounce.
`timescale 1ns/1ps
module wim_switch (
    input  wire  clk_sys,
    input  wire  level,
    input  wire  bounce,
    output wire  wake_pin
);
    logic chatter = 1'b0;
    // Chatter flips every cycle so a bouncing contact never looks stable to the filter.
    always @(posedge clk_sys) chatter <= ~chatter;
    assign wake_pin = bounce ? chatter : level;
endmodule

//--- verif/wim_top_test.sv
// Self-checking bench of the wake input monitor.
`timescale 1ns/1ps
`include "wim_map.vh"
module wim_top_test;
    localparam int FILT = 8;
    localparam int PUL  = 16;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic [1:0] chip_mode = `WIM_MODE_NORMAL;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       level = 1'b0;
    logic       bounce = 1'b0;
    logic [7:0] n_int = 8'h00;
    logic [7:0] n_wake = 8'h00;
    logic [7:0] n_rst = 8'h00;
    logic [7:0] d_int, d_wake, d_rst;
    wire  [7:0] reg_rdata;
    wire        interrupt_out_n, wake_req, restart_req, buck_pwm_sel, buck_pin_ctrl;
    wire        pull_up_en, pull_down_en, wake_pin;
    int         num_errors = 0;
    int         checks_done = 0;
    int         seed = 70;
    int         i;
    wim_switch wim_switch_i (.clk_sys(clk_sys), .level(level), .bounce(bounce), .wake_pin(wake_pin));
    wim_top #(.FILTER_CYC(FILT), .PULSE_CYC(PUL), .GAP_CYC(PUL)) wim_top_i (
        .clk_sys(clk_sys), .nrst(nrst), .wake_pin(wake_pin), .chip_mode(chip_mode), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .interrupt_out_n(interrupt_out_n), .wake_req(wake_req), .restart_req(restart_req),
        .buck_pwm_sel(buck_pwm_sel), .buck_pin_ctrl(buck_pin_ctrl), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en));
    initial forever #2 clk_sys = ~clk_sys;
    always @(negedge interrupt_out_n) n_int <= n_int + 8'h01;
    always @(posedge wake_req) n_wake <= n_wake + 8'h01;
    always @(posedge restart_req) n_rst <= n_rst + 8'h01;
    function automatic logic [7:0] pull_exp(input logic [1:0] p, input logic lvl);
        if (p == `WIM_PULL_AUTO) return lvl ? 8'h02 : 8'h01;
        return {6'h00, p};
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1 chk(what, reg_rdata, exp);
    endtask
    // Bounces for nb cycles, then settles on lvl; nothing may happen within the filter time.
    task automatic step(input logic lvl, input int nb);
        logic [7:0] i0, w0, r0;
        i0 = n_int;
        w0 = n_wake;
        r0 = n_rst;
        @(posedge clk_sys);
        bounce <= (nb > 0);
        level <= lvl;
        repeat (nb) @(posedge clk_sys);
        bounce <= 1'b0;
        repeat (FILT) @(posedge clk_sys);
        chk("early event", n_int - i0 + n_wake - w0 + n_rst - r0, 8'h00);
        repeat (PUL + 40) @(posedge clk_sys);
        d_int = n_int - i0;
        d_wake = n_wake - w0;
        d_rst = n_rst - r0;
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        for (i = 0; i < 7; i++) rd(i == 6 ? 4'hf : i[3:0], 8'h00, "reset or unmapped");
        wr(`WIM_OFF_WAKE_CTRL1, 8'h01 | 8'($random(seed)));
        rd(`WIM_OFF_WAKE_CTRL1, 8'h01, "enable");
        wr(`WIM_OFF_PULL_CTRL, {6'h00, `WIM_PULL_AUTO});
        for (i = 0; i < 4; i++) begin
            chip_mode <= i[1:0];
            step(~level, {$random(seed)} % 24);
            chk("interrupt", d_int, {7'h00, i < 2});
            chk("wake", d_wake, {7'h00, i == 2});
            chk("restart", d_rst, {7'h00, i == 3});
            rd(`WIM_OFF_STATUS0, 8'h01, "event flag");
            rd(`WIM_OFF_STATUS0, 8'h00, "flag cleared");
            rd(`WIM_OFF_LEVEL_STAT, {7'h00, level & (i < 2)}, "level");
            chk("auto pull", {6'h00, pull_up_en, pull_down_en}, pull_exp(`WIM_PULL_AUTO, level));
        end
        chip_mode <= `WIM_MODE_NORMAL;
        step(level, 5 + {$random(seed)} % 30);
        chk("bounce only", d_int, 8'h00);
        wr(`WIM_OFF_WAKE_CTRL1, 8'hfe & 8'($random(seed)));
        chip_mode <= `WIM_MODE_SLEEP;
        step(~level, 0);
        chk("disabled wake", d_wake, 8'h00);
        rd(`WIM_OFF_STATUS0, 8'h00, "disabled flag");
        chip_mode <= `WIM_MODE_FAILSAFE;
        step(~level, 0);
        chk("fail-safe restart", d_rst, 8'h01);
        rd(`WIM_OFF_STATUS0, 8'h01, "fail-safe flag");
        wr(`WIM_OFF_WAKE_CTRL1, 8'h01);
        wr(`WIM_OFF_HW_CTRL0, 8'h01);
        rd(`WIM_OFF_HW_CTRL0, 8'h01, "regulator bit");
        chip_mode <= `WIM_MODE_STOP;
        for (i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            level <= ~level;
            repeat (4) @(posedge clk_sys);
            #1 chk("pwm select", {7'h00, buck_pwm_sel}, {7'h00, level});
            chk("pin control", {7'h00, buck_pin_ctrl}, 8'h01);
            repeat (60) @(posedge clk_sys);
        end
        chip_mode <= `WIM_MODE_SLEEP;
        step(~level, 0);
        chk("wake with steering", d_wake, 8'h01);
        chk("pin control off", {7'h00, buck_pin_ctrl}, 8'h00);
        for (i = 0; i < 3; i++) begin
            wr(`WIM_OFF_PULL_CTRL, i[7:0]);
            repeat (2) @(posedge clk_sys);
            chk("pull select", {6'h00, pull_up_en, pull_down_en}, pull_exp(i[1:0], level));
            rd(`WIM_OFF_PULL_CTRL, i[7:0], "pull readback");
        end
        test_done();
    end
endmodule
